/* verilog/dpa_pkg.sv */
// Shared constants and types for the dual processor bus arbiter
package dpa_pkg;
  localparam logic [1:0]  ID_SINGLE   = 2'h0;
  localparam logic [1:0]  ID_P1       = 2'h1;
  localparam logic [1:0]  ID_P2       = 2'h2;
  localparam logic [1:0]  ID_RSVD     = 2'h3;
  localparam int          MS_W        = 4;
  localparam int          SDRAM_MS    = 0;
  localparam int          MS_ACC      = 1;
  localparam logic [3:0]  MS_IDLE     = 4'hF;
  localparam int          MASTERSHIP_TIMEOUT_COUNTER_W      = 16;
  localparam logic [15:0] MASTERSHIP_TIMEOUT_LIMIT_RST    = 16'h0012;
  localparam logic [15:0] MASTERSHIP_TIMEOUT_COUNTER_STEP   = 16'h0002;
  localparam int          AXI_AW      = 4;
  localparam logic [3:0]  A_CTRL      = 4'h0;
  localparam logic [3:0]  A_FIRST_MODE_REGISTER     = 4'h4;
  localparam logic [3:0]  A_MASTERSHIP_TIMEOUT_LIMIT      = 4'h8;
  localparam logic [3:0]  A_STAT      = 4'hC;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] FIRST_MODE_REGISTER_RST   = 32'h0000_0000;
  localparam int          C_EXT       = 0;
  localparam int          C_COND      = 1;
  localparam int          C_SREF      = 2;
  localparam int          C_DMA       = 3;
  localparam int          C_DA        = 4;
  localparam int          C_BURST     = 5;
  localparam int          C_REFNEED   = 6;
  localparam int          C_SREFDONE  = 7;
  localparam int          C_BUSY      = 8;
  localparam int          M1_BMA      = 17;
  localparam int          M1_BMB      = 18;
  localparam int          S_MID       = 0;
  localparam int          S_MST       = 3;
  localparam int          S_BMC       = 4;
  localparam int          S_GO        = 5;
  localparam int          S_STALL     = 6;
  localparam int          S_MP        = 7;
  localparam int          S_RSVD      = 8;
  localparam int          S_MASTERSHIP_TIMEOUT_COUNTER      = 16;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ROLE_SINGLE, ROLE_SLAVE, ROLE_MASTER} dpa_role_e;
endpackage

/* verilog/dpa_link_if.sv */
// Shared bus request and bus control wires between the two processors
`timescale 1ns/1ps
`default_nettype none
interface dpa_link_if;
  import dpa_pkg::*;
  logic [1:0]      dev_br_n;
  logic [1:0]      dev_br_oe;
  logic [MS_W-1:0] dev_ms_n;
  logic [MS_W-1:0] dev_ms_oe;
  logic            dev_bus_oe;
  logic [1:0]      ptn_br_n;
  logic [1:0]      ptn_br_oe;
  logic [MS_W-1:0] ptn_ms_n;
  logic [MS_W-1:0] ptn_ms_oe;
  logic            ptn_bus_oe;
  logic [1:0]      br_n;
  logic [MS_W-1:0] ms_n;

  // Wire levels with pull-ups when nobody drives
  for (genvar k = 0; k < 2; k++) begin : g_br
    assign br_n[k] = dev_br_oe[k] ? dev_br_n[k] : (ptn_br_oe[k] ? ptn_br_n[k] : 1'b1);
  end
  for (genvar m = 0; m < MS_W; m++) begin : g_ms
    assign ms_n[m] = dev_ms_oe[m] ? dev_ms_n[m] : (ptn_ms_oe[m] ? ptn_ms_n[m] : 1'b1);
  end

  modport dev_mp (output dev_br_n, dev_br_oe, dev_ms_n, dev_ms_oe, dev_bus_oe,
                  input br_n, ms_n);
  modport ptn_mp (output ptn_br_n, ptn_br_oe, ptn_ms_n, ptn_ms_oe, ptn_bus_oe,
                  input br_n, ms_n);
endinterface // dpa_link_if
`default_nettype wire

/* verilog/dpa_partner_end.sv */
// Partner processor end of the shared bus arbitration
`timescale 1ns/1ps
`default_nettype none
module dpa_partner_end import dpa_pkg::*; (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic [1:0] i_id,
  input  wire logic       i_want,
  output var  logic       o_grant,
  output var  logic       o_is_master,
  output var  logic [2:0] o_master_id,
  dpa_link_if.ptn_mp      lnk
);
  logic [1:0]      id_s1_q;
  logic [1:0]      id_q;
  logic [1:0]      br_s1_q;
  logic [1:0]      br_s2_q;
  logic [1:0]      want_s_q;
  logic [2:0]      mid_q;
  logic [1:0]      br_n_q;
  logic [1:0]      br_oe_q;
  logic            bus_oe_q;
  logic            grant_q;
  logic            master_q;
  logic [MS_W-1:0] ms_n_q;
  logic [MS_W-1:0] ms_oe_q;
  logic            own;
  logic            mp;
  logic            ml;
  logic            xfer;
  logic            drive_d;
  dpa_role_e       role;

  always_ff @(posedge i_sys_clk) begin
    id_s1_q <= i_id;
    id_q    <= id_s1_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      br_s1_q  <= 2'h3;
      br_s2_q  <= 2'h3;
      want_s_q <= 2'h0;
    end else begin
      br_s1_q  <= lnk.br_n;
      br_s2_q  <= br_s1_q;
      want_s_q <= {want_s_q[0], i_want};
    end
  end

  assign own  = (id_q == ID_P2);
  assign mp   = (id_q == ID_P1) || (id_q == ID_P2);
  assign ml   = (mid_q[1:0] == ID_P2);
  assign xfer = mp && br_s2_q[ml] && !br_s2_q[!ml];

  always_comb begin
    if (!mp) begin
      role = ROLE_SINGLE;
    end else if (mid_q[1:0] == id_q) begin
      role = ROLE_MASTER;
    end else begin
      role = ROLE_SLAVE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mid_q <= {1'b0, ID_P1};
    end else if (!mp) begin
      mid_q <= {1'b0, ID_SINGLE};
    end else if (xfer) begin
      mid_q <= ml ? {1'b0, ID_P1} : {1'b0, ID_P2};
    end
  end

  assign drive_d = (role != ROLE_SLAVE) && !xfer;

  // Request only the line chosen by the identity
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      br_n_q   <= 2'h3;
      br_oe_q  <= 2'h0;
      bus_oe_q <= 1'b0;
      grant_q  <= 1'b0;
      master_q <= 1'b0;
      ms_n_q   <= MS_IDLE;
      ms_oe_q  <= '0;
    end else begin
      br_n_q      <= 2'h3;
      br_n_q[own] <= !(mp && want_s_q[1]);
      br_oe_q     <= mp ? (own ? 2'b10 : 2'b01) : 2'b00;
      bus_oe_q    <= drive_d;
      ms_oe_q     <= {MS_W{drive_d}};
      grant_q     <= drive_d && want_s_q[1];
      master_q    <= (role == ROLE_MASTER);
      ms_n_q      <= MS_IDLE;
      if (drive_d && want_s_q[1]) begin
        ms_n_q[MS_ACC] <= 1'b0;
      end
    end
  end

  assign lnk.ptn_br_n   = br_n_q;
  assign lnk.ptn_br_oe  = br_oe_q;
  assign lnk.ptn_ms_n   = ms_n_q;
  assign lnk.ptn_ms_oe  = ms_oe_q;
  assign lnk.ptn_bus_oe = bus_oe_q;
  assign o_grant        = grant_q;
  assign o_is_master    = master_q;
  assign o_master_id    = mid_q;
endmodule // dpa_partner_end
`default_nettype wire

/* verilog/dpa_dev_end.sv */
// Device processor end of the shared bus arbitration with AXI4-Lite registers
//
// Notes on behaviour
// - Drive own request line, watch the other
// - Identity 01 uses line one, 10 line two
// - Identity inputs static, change only in reset
// - 01/10 multiprocessor, 00 single, 11 reserved
// - Identity 01 holds controls stable in reset
// - Status bits 2:0 show current master identity
// - Master condition true only if mode bits clear
// - Slave requests early, samples other line later
// - Mastership moves only in a transition cycle
// - Master keeps bus while requesting or both idle
// - Old master releases bus, new drives next
// - Selects go inactive first, SDRAM select stays
// - Slave access waits for mastership, core stalls
// - Master drops request when done, keeps controls
// - Conditional external access always requests bus
// - Refresh need holds request until self-refresh
// - Keep requesting during SDRAM burst
// - Waiting DMA requests, dropped during DA access
// - Software sets limit as twice cycles minus two
// - Load timeout counter on each acquisition
// - Decrement per double-rate cycle when contended; the code decrements only while C_BUSY is set
// - Reload counter whenever request is dropped
// - At zero finish access, drop request, hold off
// - Cycle counts are on the input clock
`timescale 1ns/1ps
`default_nettype none
module dpa_dev_end import dpa_pkg::*; (
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  input  wire logic [1:0]        i_id,
  input  wire logic              i_s_axi_awvalid,
  output var  logic              o_s_axi_awready,
  input  wire logic [AXI_AW-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_wvalid,
  output var  logic              o_s_axi_wready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  output var  logic              o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  output var  logic [1:0]        o_s_axi_bresp,
  input  wire logic              i_s_axi_arvalid,
  output var  logic              o_s_axi_arready,
  input  wire logic [AXI_AW-1:0] i_s_axi_araddr,
  output var  logic              o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  output var  logic [31:0]       o_s_axi_rdata,
  output var  logic [1:0]        o_s_axi_rresp,
  dpa_link_if.dev_mp             lnk
);
  logic [1:0]        id_s1_q;
  logic [1:0]        id_q;
  logic [1:0]        br_s1_q;
  logic [1:0]        br_s2_q;
  logic              rst_done_q;
  logic [2:0]        mid_q;
  logic [1:0]        br_n_q;
  logic [1:0]        br_oe_q;
  logic              bus_oe_q;
  logic [MS_W-1:0]   ms_n_q;
  logic [MS_W-1:0]   ms_oe_q;
  logic [MASTERSHIP_TIMEOUT_COUNTER_W-1:0] mastership_timeout_counter_q;
  logic [MASTERSHIP_TIMEOUT_COUNTER_W-1:0] mastership_timeout_limit_q;
  logic [31:0]       ctrl_q;
  logic [31:0]       first_mode_register_q;
  logic              ref_hold_q;
  logic              go_q;
  logic              stall_q;
  logic              hold_q;
  logic              awready_q;
  logic              wready_q;
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_d;
  logic [1:0]        rresp_d;
  logic [31:0]       stat_w;
  logic              own;
  logic              mp;
  logic              ml;
  logic              xfer;
  logic              acq;
  logic              oth_req;
  logic              tmo;
  logic              busy;
  logic              acc;
  logic              core_want;
  logic              req_d;
  logic              go_d;
  logic              drive_d;
  logic              wr_en;
  logic [MS_W-1:0]   ms_d;
  dpa_role_e         role;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Identity straps sampled continuously so they hold during reset
  always_ff @(posedge i_sys_clk) begin
    id_s1_q <= i_id;
    id_q    <= id_s1_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      br_s1_q    <= 2'h3;
      br_s2_q    <= 2'h3;
      rst_done_q <= 1'b0;
    end else begin
      br_s1_q    <= lnk.br_n;
      br_s2_q    <= br_s1_q;
      rst_done_q <= 1'b1;
    end
  end

  assign own     = (id_q == ID_P2);
  assign mp      = (id_q == ID_P1) || (id_q == ID_P2);
  assign ml      = (mid_q[1:0] == ID_P2);
  assign xfer    = mp && br_s2_q[ml] && !br_s2_q[!ml];
  assign acq     = xfer && ((ml ? ID_P1 : ID_P2) == id_q);
  assign oth_req = !br_s2_q[!own];

  always_comb begin
    if (!mp) begin
      role = ROLE_SINGLE;
    end else if (mid_q[1:0] == id_q) begin
      role = ROLE_MASTER;
    end else begin
      role = ROLE_SLAVE;
    end
  end

  // Master identity follows transition cycles only
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mid_q <= {1'b0, ID_P1};
    end else if (!mp) begin
      mid_q <= {1'b0, ID_SINGLE};
    end else if (xfer) begin
      mid_q <= ml ? {1'b0, ID_P1} : {1'b0, ID_P2};
    end
  end

  assign busy      = ctrl_q[C_BUSY];
  assign acc       = ctrl_q[C_EXT] || ctrl_q[C_COND];
  assign core_want = acc || (ctrl_q[C_DMA] && !ctrl_q[C_DA]);
  assign tmo       = (role == ROLE_MASTER) && (mastership_timeout_counter_q == '0) && oth_req;

  always_comb begin
    case (role)
      ROLE_SLAVE:  req_d = core_want;
      ROLE_MASTER: req_d = ctrl_q[C_BURST] || ref_hold_q ||
                           (core_want && !(tmo && !busy) && !hold_q);
      default:     req_d = 1'b0;
    endcase
  end

  assign go_d    = (role != ROLE_SLAVE) && acc && !tmo && !hold_q;
  assign drive_d = (role != ROLE_SLAVE) && !xfer;

  always_comb begin
    ms_d = MS_IDLE;
    if (go_d) begin
      ms_d[MS_ACC] = 1'b0;
    end
    if (drive_d && ctrl_q[C_BURST]) begin
      ms_d[SDRAM_MS] = 1'b0;
    end
  end

  // Refresh request held until self-refresh is entered; setting wins
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_hold_q <= 1'b0;
    end else if (ctrl_q[C_REFNEED] || ctrl_q[C_SREF]) begin
      ref_hold_q <= 1'b1;
    end else if (ctrl_q[C_SREFDONE]) begin
      ref_hold_q <= 1'b0;
    end
  end

  // After a timeout no new access starts until the bus is handed over or the other end stops requesting,
  // so the reload on release cannot re-arm the request and selects
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_q <= 1'b0;
    end else if (tmo && !busy) begin
      hold_q <= 1'b1;
    end else if ((role != ROLE_MASTER) || !oth_req) begin
      hold_q <= 1'b0;
    end
  end

  // Timeout counter, two steps per input clock for the double rate
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mastership_timeout_counter_q <= MASTERSHIP_TIMEOUT_LIMIT_RST;
    end else if (acq || ((role == ROLE_MASTER) && br_n_q[own])) begin
      mastership_timeout_counter_q <= mastership_timeout_limit_q;
    end else if ((role == ROLE_MASTER) && busy && oth_req && (mastership_timeout_counter_q != '0)) begin
      mastership_timeout_counter_q <= (mastership_timeout_counter_q > MASTERSHIP_TIMEOUT_COUNTER_STEP) ? mastership_timeout_counter_q - MASTERSHIP_TIMEOUT_COUNTER_STEP : '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      br_n_q   <= 2'h3;
      br_oe_q  <= 2'h0;
      bus_oe_q <= 1'b0;
      go_q     <= 1'b0;
      stall_q  <= 1'b0;
    end else begin
      br_n_q      <= 2'h3;
      br_n_q[own] <= !req_d;
      br_oe_q     <= mp ? (own ? 2'b10 : 2'b01) : 2'b00;
      bus_oe_q    <= drive_d;
      go_q        <= go_d;
      stall_q     <= ctrl_q[C_EXT] && !go_d;
    end
  end

  // Memory controls: identity 01 keeps them at idle levels during reset
  always_ff @(posedge i_sys_clk) begin
    if (!rst_done_q) begin
      ms_n_q  <= MS_IDLE;
      ms_oe_q <= {MS_W{id_q == ID_P1}};
    end else begin
      ms_n_q  <= ms_d;
      ms_oe_q <= {MS_W{drive_d}};
    end
  end

  // AXI write channel
  assign wr_en = aw_hold_q && w_hold_q && !bvalid_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OK;
    end else begin
      if (i_s_axi_awvalid && awready_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= i_s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (i_s_axi_wvalid && wready_q) begin
        w_hold_q <= 1'b1;
        wdata_q  <= i_s_axi_wdata;
        wstrb_q  <= i_s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_en) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q == A_CTRL || awaddr_q == A_FIRST_MODE_REGISTER ||
                      awaddr_q == A_MASTERSHIP_TIMEOUT_LIMIT || awaddr_q == A_STAT) ? RESP_OK : RESP_SLVERR;
      end
      if (bvalid_q && i_s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q  <= CTRL_RST;
      first_mode_register_q <= FIRST_MODE_REGISTER_RST;
      mastership_timeout_limit_q  <= MASTERSHIP_TIMEOUT_LIMIT_RST;
    end else if (wr_en) begin
      case (awaddr_q)
        A_CTRL:  ctrl_q  <= merge(ctrl_q, wdata_q, wstrb_q);
        A_FIRST_MODE_REGISTER: first_mode_register_q <= merge(first_mode_register_q, wdata_q, wstrb_q);
        A_MASTERSHIP_TIMEOUT_LIMIT:  mastership_timeout_limit_q  <= MASTERSHIP_TIMEOUT_COUNTER_W'(merge({16'h0000, mastership_timeout_limit_q}, wdata_q, wstrb_q));
        default: ;
      endcase
    end
  end

  // Status word
  always_comb begin
    stat_w                      = '0;
    stat_w[S_MID +: 3]          = mid_q;
    stat_w[S_MST]               = (role == ROLE_MASTER);
    stat_w[S_BMC]               = (role == ROLE_MASTER) &&
                                  !first_mode_register_q[M1_BMA] && !first_mode_register_q[M1_BMB];
    stat_w[S_GO]                = go_q;
    stat_w[S_STALL]             = stall_q;
    stat_w[S_MP]                = mp;
    stat_w[S_RSVD]              = (id_q == ID_RSVD);
    stat_w[S_MASTERSHIP_TIMEOUT_COUNTER +: MASTERSHIP_TIMEOUT_COUNTER_W]    = mastership_timeout_counter_q;
  end

  always_comb begin
    rdata_d = '0;
    rresp_d = RESP_OK;
    case (i_s_axi_araddr)
      A_CTRL:  rdata_d = ctrl_q;
      A_FIRST_MODE_REGISTER: rdata_d = first_mode_register_q;
      A_MASTERSHIP_TIMEOUT_LIMIT:  rdata_d = {16'h0000, mastership_timeout_limit_q};
      A_STAT:  rdata_d = stat_w;
      default: rresp_d = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OK;
    end else if (i_s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end else if (rvalid_q && i_s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign lnk.dev_br_n   = br_n_q;
  assign lnk.dev_br_oe  = br_oe_q;
  assign lnk.dev_ms_n   = ms_n_q;
  assign lnk.dev_ms_oe  = ms_oe_q;
  assign lnk.dev_bus_oe = bus_oe_q;
  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready  = wready_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;
endmodule // dpa_dev_end
`default_nettype wire

/* verification/dpa_link_checker.sv */
// Concurrent checks on the shared request and bus drive wires
`timescale 1ns/1ps
`default_nettype none
module dpa_link_checker import dpa_pkg::*; (
  input wire logic            i_sys_clk,
  input wire logic            i_reset_n,
  input wire logic [1:0]      dev_br_oe,
  input wire logic [MS_W-1:0] dev_ms_n,
  input wire logic [MS_W-1:0] dev_ms_oe,
  input wire logic            dev_bus_oe,
  input wire logic [1:0]      ptn_br_oe,
  input wire logic [MS_W-1:0] ptn_ms_n,
  input wire logic [MS_W-1:0] ptn_ms_oe,
  input wire logic            ptn_bus_oe,
  input wire logic [1:0]      br_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  // Master released its line while the other end keeps requesting
  sequence s_dev_release;
    dev_bus_oe ##0 (br_n[0] && !br_n[1])[*2];
  endsequence
  sequence s_ptn_release;
    ptn_bus_oe ##0 (br_n[1] && !br_n[0])[*2];
  endsequence

  a_single_bus_driver: assert property (!(dev_bus_oe && ptn_bus_oe))
    else $error("both ends drive the bus");
  a_own_line_only: assert property (!dev_br_oe[1] && !ptn_br_oe[0])
    else $error("request line of the other end driven");
  a_dev_keeps_bus: assert property (
    ((!br_n[0] || br_n[1])[*5] ##0 dev_bus_oe) |=> dev_bus_oe)
    else $error("device lost the bus without a transition cycle");
  a_ptn_keeps_bus: assert property (
    ((!br_n[1] || br_n[0])[*5] ##0 ptn_bus_oe) |=> ptn_bus_oe)
    else $error("partner lost the bus without a transition cycle");
  a_dev_hands_over: assert property (s_dev_release |-> ##[1:4] ptn_bus_oe)
    else $error("partner did not take the bus after transition");
  a_ptn_hands_over: assert property (s_ptn_release |-> ##[1:4] dev_bus_oe)
    else $error("device did not take the bus after transition");
  a_dev_sel_high: assert property ($fell(dev_ms_oe[MS_ACC]) |->
    $past(dev_ms_n[3:1]) == 3'h7)
    else $error("device released a select that was still active");
  a_ptn_sel_high: assert property ($fell(ptn_ms_oe[MS_ACC]) |->
    $past(ptn_ms_n[3:1]) == 3'h7)
    else $error("partner released a select that was still active");
  a_ptn_sel_master: assert property (!ptn_ms_n[MS_ACC] |->
    ptn_ms_oe[MS_ACC] && ptn_bus_oe)
    else $error("partner drives a select while slave");
endmodule // dpa_link_checker
`default_nettype wire

/* verification/dual_processor_bus_arbiter_bench.sv */
// Self-checking bench for both processor ends joined over the shared link
`timescale 1ns/1ps
`default_nettype none
module dual_processor_bus_arbiter_bench import dpa_pkg::*; ();
  logic              sys_clk;
  logic              reset_n;
  logic              awvalid;
  logic              awready;
  logic [AXI_AW-1:0] awaddr;
  logic              wvalid;
  logic              wready;
  logic [31:0]       wdata;
  logic              bvalid;
  logic              bready;
  logic [1:0]        bresp;
  logic              arvalid;
  logic              arready;
  logic [AXI_AW-1:0] araddr;
  logic              rvalid;
  logic              rready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              want;
  logic              grant;
  logic              is_master;
  logic [2:0]        master_id;
  int                num_errors = 0;
  int                num_checks = 0;
  localparam logic [31:0] M1V [4] = '{32'h0002_0000, 32'h0004_0000, 32'h0006_0000, 32'h0};
  localparam int          HOLDB [3] = '{C_BURST, C_REFNEED, C_SREF};

  dpa_link_if lnk ();

  dpa_dev_end dpa_dev_end_inst (
    .i_sys_clk       (sys_clk),
    .i_reset_n       (reset_n),
    .i_id            (ID_P1),
    .i_s_axi_awvalid (awvalid),
    .o_s_axi_awready (awready),
    .i_s_axi_awaddr  (awaddr),
    .i_s_axi_wvalid  (wvalid),
    .o_s_axi_wready  (wready),
    .i_s_axi_wdata   (wdata),
    .i_s_axi_wstrb   (4'hF),
    .o_s_axi_bvalid  (bvalid),
    .i_s_axi_bready  (bready),
    .o_s_axi_bresp   (bresp),
    .i_s_axi_arvalid (arvalid),
    .o_s_axi_arready (arready),
    .i_s_axi_araddr  (araddr),
    .o_s_axi_rvalid  (rvalid),
    .i_s_axi_rready  (rready),
    .o_s_axi_rdata   (rdata),
    .o_s_axi_rresp   (rresp),
    .lnk             (lnk)
  );

  dpa_partner_end dpa_partner_end_inst (
    .i_sys_clk   (sys_clk),
    .i_reset_n   (reset_n),
    .i_id        (ID_P2),
    .i_want      (want),
    .o_grant     (grant),
    .o_is_master (is_master),
    .o_master_id (master_id),
    .lnk         (lnk)
  );

  dpa_link_checker dpa_link_checker_inst (
    .i_sys_clk  (sys_clk),
    .i_reset_n  (reset_n),
    .dev_br_oe  (lnk.dev_br_oe),
    .dev_ms_n   (lnk.dev_ms_n),
    .dev_ms_oe  (lnk.dev_ms_oe),
    .dev_bus_oe (lnk.dev_bus_oe),
    .ptn_br_oe  (lnk.ptn_br_oe),
    .ptn_ms_n   (lnk.ptn_ms_n),
    .ptn_ms_oe  (lnk.ptn_ms_oe),
    .ptn_bus_oe (lnk.ptn_bus_oe),
    .br_n       (lnk.br_n)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge sys_clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic stat(output logic [31:0] s);
    logic [1:0] r;
    rd(A_STAT, s, r);
  endtask

  // Waits a bounded time for the partner to reach the given mastership
  task automatic wait_ptn(input logic m);
    int n;
    n = 0;
    while (is_master !== m && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk("partner mastership", 32'(is_master), 32'(m));
  endtask

  task automatic t_reset;
    repeat (4) @(posedge sys_clk);
    chk("request wires in reset", 32'(lnk.br_n), 32'h3);
    chk("bus drive in reset", 32'({lnk.dev_bus_oe, lnk.ptn_bus_oe}), 32'h0);
    chk("selects held in reset", 32'({lnk.dev_ms_oe, lnk.ms_n}), 32'hFF);
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask

  task automatic t_regs;
    logic [31:0] s;
    logic [1:0]  r;
    rd(A_MASTERSHIP_TIMEOUT_LIMIT, s, r);
    chk("timeout limit reset", s, 32'h12);
    rd(4'h2, s, r);
    chk("unmapped response", 32'(r), 32'(RESP_SLVERR));
    wr(A_STAT, 32'h0);
    stat(s);
    chk("master id after reset", 32'(s[S_MID+:3]), 32'h1);
    chk("multiprocessor mode", 32'({s[S_RSVD], s[S_MP]}), 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(A_FIRST_MODE_REGISTER, M1V[i]);
      stat(s);
      chk("master condition", 32'(s[S_BMC]), 32'(i == 3));
    end
  endtask

  task automatic t_handover;
    logic [31:0] s;
    @(posedge sys_clk);
    want <= 1'b1;
    wait_ptn(1'b1);
    chk("partner master id", 32'(master_id), 32'h2);
    stat(s);
    chk("status as slave", 32'(s[3:0]), 32'h2);
    chk("bus drive swap", 32'({lnk.dev_bus_oe, lnk.ptn_bus_oe, grant}), 32'h3);
    wr(A_CTRL, 32'(1) << C_COND);
    repeat (3) @(posedge sys_clk);
    chk("conditional request", 32'(lnk.br_n), 32'h0);
    wr(A_CTRL, 32'(1) << C_DMA);
    repeat (3) @(posedge sys_clk);
    chk("dma request", 32'(lnk.br_n[0]), 32'h0);
    wr(A_CTRL, (32'(1) << C_DMA) | (32'(1) << C_DA));
    repeat (3) @(posedge sys_clk);
    chk("dma request during group access", 32'(lnk.br_n[0]), 32'h1);
    wr(A_CTRL, 32'(1) << C_EXT);
    stat(s);
    chk("slave access stalled", 32'(s[S_STALL:S_GO]), 32'h2);
    @(posedge sys_clk);
    want <= 1'b0;
    wait_ptn(1'b0);
    stat(s);
    chk("status as master", 32'(s[6:0]), 32'h39);
  endtask

  task automatic t_master;
    wr(A_CTRL, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("idle master keeps bus", 32'({lnk.br_n[0], lnk.dev_bus_oe}), 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(A_CTRL, 32'(1) << HOLDB[i]);
      repeat (3) @(posedge sys_clk);
      chk("refresh or burst request", 32'(lnk.br_n[0]), 32'h0);
    end
    wr(A_CTRL, 32'(1) << C_SREFDONE);
    repeat (3) @(posedge sys_clk);
    chk("request after self refresh", 32'(lnk.br_n[0]), 32'h1);
  endtask

  task automatic t_timeout;
    logic [31:0] s;
    wr(A_MASTERSHIP_TIMEOUT_LIMIT, 32'h6);
    stat(s);
    chk("counter reload", 32'(s[31:S_MASTERSHIP_TIMEOUT_COUNTER]), 32'h6);
    wr(A_CTRL, (32'(1) << C_EXT) | (32'(1) << C_BUSY));
    want <= 1'b1;
    repeat (12) @(posedge sys_clk);
    stat(s);
    chk("counter expired", 32'(s[31:S_MASTERSHIP_TIMEOUT_COUNTER]), 32'h0);
    chk("busy access finishes", 32'({is_master, s[S_GO]}), 32'h0);
    wr(A_CTRL, 32'(1) << C_EXT);
    wait_ptn(1'b1);
    wr(A_MASTERSHIP_TIMEOUT_LIMIT, 32'h8);
    @(posedge sys_clk);
    want <= 1'b0;
    wait_ptn(1'b0);
    stat(s);
    chk("counter loaded on acquisition", 32'(s[31:S_MASTERSHIP_TIMEOUT_COUNTER]), 32'h8);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    awvalid = 1'b0;
    awaddr  = '0;
    wvalid  = 1'b0;
    wdata   = '0;
    bready  = 1'b0;
    arvalid = 1'b0;
    araddr  = '0;
    rready  = 1'b0;
    want    = 1'b0;
    t_reset;
    t_regs;
    t_handover;
    t_master;
    t_timeout;
    give_verdict;
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict;
  end
endmodule // dual_processor_bus_arbiter_bench
`default_nettype wire
